// ==== hdl/pfr_top.sv ====
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Tenth-second down timer
// ----------------------------------------------------------------
module pfr_tenth_timer #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic i_cancel,
	input wire logic [W-1:0] i_load,
	// Status
	output logic o_running,
	output logic o_done
);
	logic [W-1:0] remain;
	logic [W-1:0] next_remain;
	logic done;
	logic next_done;

	always_comb begin
		next_remain = remain;
		next_done = 1'b0;
		if (i_start) begin
			next_remain = i_load;
		end else if (i_cancel) begin
			next_remain = '0;
		end else if (i_tick && remain != '0) begin
			next_remain = remain - W'(1);
			next_done = (remain == W'(1));
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			remain <= '0;
			done <= 1'b0;
		end else begin
			remain <= next_remain;
			done <= next_done;
		end
	end

	assign o_running = (remain != '0);
	assign o_done = done;
endmodule : pfr_tenth_timer

// ----------------------------------------------------------------
// Pulse filter, counter and relay controller
// ----------------------------------------------------------------
module pfr_top
	import pfr_pkg::*;
#(
	parameter int FILT_BASE_CYC = FILT_10HZ_CYC,
	parameter int TICK_CYC = TENTH_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Pins
	input wire logic i_pulse,
	input wire logic i_start,
	// Count retention
	input wire logic [9:0] i_saved_count,
	input wire logic i_saved_valid,
	output logic [9:0] o_count,
	// Relays and status
	output logic o_relay_one,
	output logic o_relay_two,
	output logic o_cycle_active
);
	localparam int FW = $clog2(FILT_BASE_CYC + 1);
	localparam int TW = $clog2(TICK_CYC + 1);

	if (FILT_BASE_CYC < FILT_OFF_CYC || TICK_CYC < 1) begin : g_bad_param
		$error("pfr_top: filter base or tick count out of range");
	end

	function automatic logic [9:0] clamp_val(input logic [9:0] v);
		clamp_val = (v > COUNT_MAX) ? COUNT_MAX : v;
	endfunction : clamp_val

	function automatic logic contact(input pfr_relay_mode_t m, input logic act, input logic bus);
		case (m)
			RELAY_CLOSED_ACTIVE: contact = act;
			RELAY_OPEN_ACTIVE: contact = ~act;
			RELAY_BUS_DRIVEN: contact = bus;
			default: contact = 1'b0;
		endcase
	endfunction : contact

	// ----------------------------------------------------------------
	// Input synchronisers, debounce filter, tenth tick
	// ----------------------------------------------------------------
	logic [FW-1:0] filt_lim [0:FILT_STEPS];
	for (genvar g = 0; g <= FILT_STEPS; g++) begin : g_lim
		if (g == 0) begin : g_off
			assign filt_lim[g] = FW'(FILT_OFF_CYC);
		end else begin : g_on
			assign filt_lim[g] = FW'((FILT_BASE_CYC + g - 1) / g);
		end
	end

	pfr_cfg_t cfg;
	logic pulse_s1, pulse_s2, start_s1, start_s2, start_prev;
	logic filt_level, next_filt_level, strobe, next_strobe;
	logic [FW-1:0] stable_cnt, next_stable_cnt;
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;
	logic [3:0] sel_idx;

	always_comb begin
		sel_idx = (cfg.filter_sel > 4'(FILT_STEPS)) ? 4'(FILT_STEPS) : cfg.filter_sel;
		next_filt_level = filt_level;
		next_stable_cnt = '0;
		next_strobe = 1'b0;
		if (pulse_s2 != filt_level) begin
			next_stable_cnt = stable_cnt + FW'(1);
			if (next_stable_cnt >= filt_lim[sel_idx]) begin
				next_filt_level = pulse_s2;
				next_stable_cnt = '0;
				next_strobe = pulse_s2;
			end
		end
		next_tick = (tick_cnt == TW'(TICK_CYC - 1));
		next_tick_cnt = next_tick ? '0 : tick_cnt + TW'(1);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pulse_s1 <= 1'b0;
			pulse_s2 <= 1'b0;
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_prev <= 1'b0;
			filt_level <= 1'b0;
			stable_cnt <= '0;
			strobe <= 1'b0;
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			pulse_s1 <= i_pulse;
			pulse_s2 <= pulse_s1;
			start_s1 <= i_start;
			start_s2 <= start_s1;
			start_prev <= start_s2;
			filt_level <= next_filt_level;
			stable_cnt <= next_stable_cnt;
			strobe <= next_strobe;
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ----------------------------------------------------------------
	// APB register file
	// ----------------------------------------------------------------
	pfr_cfg_t next_cfg;
	logic [1:0] bus_relay, next_bus_relay;
	logic [31:0] rdata, next_rdata;
	logic apb_wr, apb_setup_rd, mapped, cmd_init;
	logic [9:0] count;
	logic [1:0] active, relay_out;
	pfr_cycle_t state;

	always_comb begin
		mapped = (i_paddr == REG_CTRL) || (i_paddr == REG_THRESH) || (i_paddr == REG_HOLD) ||
			(i_paddr == REG_DELAY) || (i_paddr == REG_CMD) || (i_paddr == REG_RELAY) ||
			(i_paddr == REG_COUNT) || (i_paddr == REG_STATUS);
		apb_wr = i_psel && i_penable && i_pwrite && mapped;
		apb_setup_rd = i_psel && !i_penable && !i_pwrite;
		cmd_init = apb_wr && (i_paddr == REG_CMD) && i_pwdata[CMD_INIT_BIT];
		next_cfg = cfg;
		next_bus_relay = bus_relay;
		if (apb_wr) begin
			case (i_paddr)
				REG_CTRL: begin
					next_cfg.batch_mode = i_pwdata[CTRL_BATCH_BIT];
					next_cfg.count_down = i_pwdata[CTRL_DOWN_BIT];
					next_cfg.autoreset_enable = i_pwdata[CTRL_AUTO_BIT];
					next_cfg.filter_sel = i_pwdata[CTRL_FILT_LSB +: 4];
					next_cfg.relay_one_mode = pfr_relay_mode_t'(i_pwdata[CTRL_MODE1_LSB +: 2]);
					next_cfg.relay_two_mode = pfr_relay_mode_t'(i_pwdata[CTRL_MODE2_LSB +: 2]);
				end
				REG_THRESH: begin
					next_cfg.main_threshold = clamp_val(i_pwdata[0 +: VAL_W]);
					next_cfg.advance_threshold = clamp_val(i_pwdata[HI_FIELD_LSB +: VAL_W]);
				end
				REG_HOLD: begin
					next_cfg.relay_one_hold_time = clamp_val(i_pwdata[0 +: VAL_W]);
					next_cfg.relay_two_hold_time = clamp_val(i_pwdata[HI_FIELD_LSB +: VAL_W]);
				end
				REG_DELAY: begin
					next_cfg.autoreset_delay = clamp_val(i_pwdata[0 +: VAL_W]);
				end
				REG_RELAY: begin
					if (cfg.relay_one_mode == RELAY_BUS_DRIVEN) begin
						next_bus_relay[0] = i_pwdata[0];
					end
					if (cfg.relay_two_mode == RELAY_BUS_DRIVEN) begin
						next_bus_relay[1] = i_pwdata[1];
					end
				end
				default: begin
				end
			endcase
		end
		next_rdata = '0;
		case (i_paddr)
			REG_CTRL: begin
				next_rdata[CTRL_BATCH_BIT] = cfg.batch_mode;
				next_rdata[CTRL_DOWN_BIT] = cfg.count_down;
				next_rdata[CTRL_AUTO_BIT] = cfg.autoreset_enable;
				next_rdata[CTRL_FILT_LSB +: 4] = cfg.filter_sel;
				next_rdata[CTRL_MODE1_LSB +: 2] = cfg.relay_one_mode;
				next_rdata[CTRL_MODE2_LSB +: 2] = cfg.relay_two_mode;
			end
			REG_THRESH: begin
				next_rdata[0 +: VAL_W] = cfg.main_threshold;
				next_rdata[HI_FIELD_LSB +: VAL_W] = cfg.advance_threshold;
			end
			REG_HOLD: begin
				next_rdata[0 +: VAL_W] = cfg.relay_one_hold_time;
				next_rdata[HI_FIELD_LSB +: VAL_W] = cfg.relay_two_hold_time;
			end
			REG_DELAY: next_rdata[0 +: VAL_W] = cfg.autoreset_delay;
			REG_RELAY: next_rdata[1:0] = relay_out;
			REG_COUNT: next_rdata[0 +: VAL_W] = count;
			REG_STATUS: begin
				next_rdata[STAT_RUN_BIT] = (state == CYC_RUN);
				next_rdata[STAT_DELAY_BIT] = (state == CYC_DELAY);
				next_rdata[STAT_ACT_LSB +: 2] = active;
			end
			default: next_rdata = '0;
		endcase
		if (!apb_setup_rd) begin
			next_rdata = rdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg <= CFG_RESET;
			bus_relay <= 2'b00;
			rdata <= '0;
		end else begin
			cfg <= next_cfg;
			bus_relay <= next_bus_relay;
			rdata <= next_rdata;
		end
	end

	assign o_prdata = rdata;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	logic [1:0] hold_start, hold_run, hold_done;
	logic [9:0] hold_time [0:1];
	logic dly_start, dly_done, init_manual;

	assign hold_time[0] = cfg.relay_one_hold_time;
	assign hold_time[1] = cfg.relay_two_hold_time;

	for (genvar r = 0; r < 2; r++) begin : g_hold
		pfr_tenth_timer #(.W(VAL_W)) u_hold (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_tick(tick),
			.i_start(hold_start[r]),
			.i_cancel(init_manual),
			.i_load(hold_time[r]),
			.o_running(hold_run[r]),
			.o_done(hold_done[r])
		);
	end

	pfr_tenth_timer #(.W(VAL_W)) u_delay (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_tick(tick),
		.i_start(dly_start),
		.i_cancel(init_manual),
		.i_load(cfg.autoreset_delay),
		.o_running(),
		.o_done(dly_done)
	);

	// ----------------------------------------------------------------
	// Counter, cycle state and relay logic
	// ----------------------------------------------------------------
	pfr_cycle_t next_state;
	logic [9:0] next_count, stepped, thr_main, next_thr_main, thr1, thr2;
	logic [1:0] armed, next_armed, next_active, hit, hit_lvl, next_relay_out;
	logic restored, next_restored, adv_over, adv_over_new, auto_init, init, keep;

	always_comb begin
		init_manual = cmd_init || (start_prev && !start_s2);
		next_state = state;
		next_count = count;
		next_thr_main = thr_main;
		next_armed = armed;
		next_active = active;
		next_restored = 1'b1;
		if (cfg.count_down) begin
			stepped = (count == COUNT_ZERO) ? COUNT_MAX : count - 10'h001;
			thr1 = COUNT_ZERO;
			thr2 = cfg.advance_threshold;
		end else begin
			stepped = (count == COUNT_MAX) ? COUNT_ZERO : count + 10'h001;
			thr1 = thr_main;
			thr2 = thr_main - cfg.advance_threshold;
		end
		adv_over = cfg.advance_threshold > thr_main;
		adv_over_new = cfg.advance_threshold > cfg.main_threshold;
		hit[0] = strobe && armed[0] && (stepped == thr1);
		hit[1] = strobe && armed[1] && !adv_over && (stepped == thr2) && cfg.batch_mode;
		hit_lvl = {1'b0, !cfg.batch_mode};
		dly_start = hit[0] && cfg.autoreset_enable && (cfg.autoreset_delay != '0) && !init_manual;
		auto_init = (hit[0] && cfg.autoreset_enable && (cfg.autoreset_delay == '0)) ||
			(dly_done && state == CYC_DELAY);
		init = init_manual || auto_init;
		if (strobe) begin
			next_count = stepped;
		end
		if (hit[0]) begin
			next_armed[0] = 1'b0;
			next_state = dly_start ? CYC_DELAY : CYC_IDLE;
		end
		if (hit[1]) begin
			next_armed[1] = 1'b0;
		end
		if (init) begin
			next_state = CYC_RUN;
			next_thr_main = cfg.main_threshold;
			next_count = cfg.count_down ? cfg.main_threshold : COUNT_ZERO;
			next_armed = {cfg.batch_mode && !adv_over_new, 1'b1};
		end
		for (int r = 0; r < 2; r++) begin
			hold_start[r] = !init_manual && (hold_time[r] != '0) &&
				(hit[r] || (r == 1 && init && cfg.batch_mode && adv_over_new));
			keep = hold_run[r] || hold_start[r];
			if (init_manual || (auto_init && !keep)) begin
				next_active[r] = cfg.batch_mode;
				if (r == 1 && cfg.batch_mode && adv_over_new) begin
					next_active[r] = 1'b0;
				end
			end else if (hit[r]) begin
				next_active[r] = hit_lvl[r];
			end else if (hold_done[r]) begin
				next_active[r] = cfg.batch_mode;
			end
		end
		if (!cfg.batch_mode) begin
			next_active[1] = 1'b0;
		end
		if (!restored) begin
			next_count = i_saved_valid ? clamp_val(i_saved_count) : count;
		end
		next_relay_out[0] = contact(cfg.relay_one_mode, next_active[0], next_bus_relay[0]);
		next_relay_out[1] = contact(cfg.relay_two_mode, next_active[1], next_bus_relay[1]);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= CYC_IDLE;
			count <= COUNT_ZERO;
			thr_main <= COUNT_ZERO;
			armed <= 2'b00;
			active <= 2'b00;
			relay_out <= 2'b00;
			restored <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			thr_main <= next_thr_main;
			armed <= next_armed;
			active <= next_active;
			relay_out <= next_relay_out;
			restored <= next_restored;
		end
	end

	assign o_count = count;
	assign o_relay_one = relay_out[0];
	assign o_relay_two = relay_out[1];
	assign o_cycle_active = (state == CYC_RUN);
endmodule : pfr_top
`default_nettype wire

// ==== hdl/pfr_pkg.sv ====
`default_nettype none
package pfr_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int FILT_OFF_NS = 50_000;
	localparam int FILT_OFF_CYC = (FILT_OFF_NS * CLK_PER_US + 999) / 1000;
	localparam int FILT_10HZ_US = 50_000;
	localparam int FILT_10HZ_CYC = FILT_10HZ_US * CLK_PER_US;
	localparam int FILT_STEPS = 9;
	localparam int TENTH_MS = 100;
	localparam int TENTH_CYC = TENTH_MS * (CLK_HZ / 1000);
	// ----------------------------------------------------------------
	// Value ranges
	// ----------------------------------------------------------------
	localparam int VAL_W = 10;
	localparam logic [9:0] COUNT_MAX = 10'h3E7;
	localparam logic [9:0] COUNT_ZERO = 10'h000;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_THRESH = 12'h004;
	localparam logic [11:0] REG_HOLD = 12'h008;
	localparam logic [11:0] REG_DELAY = 12'h00C;
	localparam logic [11:0] REG_CMD = 12'h010;
	localparam logic [11:0] REG_RELAY = 12'h014;
	localparam logic [11:0] REG_COUNT = 12'h018;
	localparam logic [11:0] REG_STATUS = 12'h01C;
	localparam int CTRL_BATCH_BIT = 0;
	localparam int CTRL_DOWN_BIT = 1;
	localparam int CTRL_AUTO_BIT = 2;
	localparam int CTRL_FILT_LSB = 4;
	localparam int CTRL_MODE1_LSB = 8;
	localparam int CTRL_MODE2_LSB = 10;
	localparam int HI_FIELD_LSB = 16;
	localparam int CMD_INIT_BIT = 0;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_DELAY_BIT = 1;
	localparam int STAT_ACT_LSB = 2;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RELAY_DISABLED = 2'b00,
		RELAY_CLOSED_ACTIVE = 2'b01,
		RELAY_OPEN_ACTIVE = 2'b10,
		RELAY_BUS_DRIVEN = 2'b11
	} pfr_relay_mode_t;
	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_RUN = 2'b01,
		CYC_DELAY = 2'b10
	} pfr_cycle_t;
	typedef struct packed {
		logic batch_mode;
		logic count_down;
		logic autoreset_enable;
		logic [3:0] filter_sel;
		pfr_relay_mode_t relay_one_mode;
		pfr_relay_mode_t relay_two_mode;
		logic [9:0] main_threshold;
		logic [9:0] advance_threshold;
		logic [9:0] relay_one_hold_time;
		logic [9:0] relay_two_hold_time;
		logic [9:0] autoreset_delay;
	} pfr_cfg_t;
	localparam pfr_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 4'h0, RELAY_DISABLED,
		RELAY_DISABLED, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
endpackage : pfr_pkg
`default_nettype wire

// ==== dv/pfr_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the pulse counter and relay controller
// ----------------------------------------------------------------
module pfr_monitor
	import pfr_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB requests
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	// Counter and relays
	input wire logic [9:0] o_count,
	input wire logic o_relay_one,
	input wire logic o_relay_two,
	input wire logic o_cycle_active
);
	logic [11:0] ctrl;
	logic [9:0] thr;
	logic [9:0] adv;
	logic [1:0] m1;
	logic [1:0] m2;
	logic wr;
	logic init;
	logic wr_relay;
	assign wr = i_psel && i_penable && i_pwrite;
	assign init = wr && i_paddr == REG_CMD && i_pwdata[0];
	assign wr_relay = wr && i_paddr == REG_RELAY;
	assign m1 = ctrl[9:8];
	assign m2 = ctrl[11:10];
	// Shadow of the control and threshold registers, updated at the same edge as the block's registers.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl <= 12'h000;
			thr <= 10'h000;
			adv <= 10'h000;
		end else if (wr && i_paddr == REG_CTRL) begin
			ctrl <= i_pwdata[11:0];
		end else if (wr && i_paddr == REG_THRESH) begin
			thr <= i_pwdata[9:0];
			adv <= i_pwdata[25:16];
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_count_range;
		o_count <= COUNT_MAX;
	endproperty
	a_count_range: assert property (p_count_range)
		else $error("count above three decades");
	property p_power_up;
		$fell(i_rst) |-> !o_relay_one && !o_relay_two && !o_cycle_active;
	endproperty
	a_power_up: assert property (p_power_up)
		else $error("relay or cycle not idle after power-up");
	property p_off_one;
		m1 == 2'b00 && $past(m1) == 2'b00 |-> !o_relay_one;
	endproperty
	a_off_one: assert property (p_off_one)
		else $error("disabled relay one closed");
	property p_off_two;
		m2 == 2'b00 && $past(m2) == 2'b00 |-> !o_relay_two;
	endproperty
	a_off_two: assert property (p_off_two)
		else $error("disabled relay two closed");
	property p_bus_write;
		wr_relay && m1 == 2'b11 |=> o_relay_one == $past(i_pwdata[0]);
	endproperty
	a_bus_write: assert property (p_bus_write)
		else $error("bus relay did not follow write");
	property p_bus_only;
		m1 == 2'b11 && $past(m1, 2) == 2'b11 && $changed(o_relay_one) |-> $past(wr_relay);
	endproperty
	a_bus_only: assert property (p_bus_only)
		else $error("bus relay moved without a write");
	property p_batch_init;
		init && ctrl[0] && m1 == 2'b01 && m2 == 2'b01 && adv <= thr
			|=> o_relay_one && o_relay_two && o_cycle_active;
	endproperty
	a_batch_init: assert property (p_batch_init)
		else $error("batch start left a relay inactive");
	property p_std_init;
		init && !ctrl[0] && m1 == 2'b01 |=> !o_relay_one && o_cycle_active;
	endproperty
	a_std_init: assert property (p_std_init)
		else $error("standard start left relay one active");
	property p_init_load;
		init && ctrl[1] |=> o_count == thr;
	endproperty
	a_init_load: assert property (p_init_load)
		else $error("down start did not load threshold");
	property p_hit_up;
		ctrl[2:0] == 3'b001 && m1 == 2'b01 && $past(o_cycle_active) && !$past(init)
			&& $changed(o_count) && o_count == thr |-> !o_relay_one && !o_cycle_active;
	endproperty
	a_hit_up: assert property (p_hit_up)
		else $error("relay one not released at threshold");
	property p_hit_down;
		ctrl[2:0] == 3'b011 && m1 == 2'b01 && $past(o_cycle_active) && !$past(init)
			&& $changed(o_count) && o_count == COUNT_ZERO |-> !o_relay_one;
	endproperty
	a_hit_down: assert property (p_hit_down)
		else $error("relay one not released at zero");
endmodule : pfr_monitor
bind pfr_top pfr_monitor u_pfr_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_count(o_count), .o_relay_one(o_relay_one), .o_relay_two(o_relay_two),
	.o_cycle_active(o_cycle_active));
`default_nettype wire

// ==== dv/pfr_pulse_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module pfr_pulse_src (
	// Clock
	input wire logic i_clk,
	// Sensor contact
	output logic o_pulse
);
	initial o_pulse = 1'b0;
	// Each pulse starts with bounce rounds of short contact chatter (none when bounce is 0), then holds both levels steadily.
	task automatic send(input int num, input int hi, input int lo, input int bounce);
		for (int p = 0; p < num; p++) begin
			repeat (bounce) begin
				o_pulse <= 1'b1;
				repeat (5) @(posedge i_clk);
				o_pulse <= 1'b0;
				repeat (5) @(posedge i_clk);
			end
			o_pulse <= 1'b1;
			repeat (hi) @(posedge i_clk);
			o_pulse <= 1'b0;
			repeat (lo) @(posedge i_clk);
		end
	endtask : send
endmodule : pfr_pulse_src
`default_nettype wire

// ==== dv/pfr_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pfr_top_tb_top
	import pfr_pkg::*;
;
	localparam int FB = 2000;
	localparam int TK = 20;
	logic i_clk, i_rst, i_psel, i_penable, i_pwrite, i_pulse, i_start;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rdata;
	logic o_pready, o_pslverr, o_relay_one, o_relay_two, o_cycle_active, rerr, watch;
	logic [9:0] o_count;
	logic [10:0] saved;
	int fails, checks_done, drops;
	pfr_top #(.FILT_BASE_CYC(FB), .TICK_CYC(TK)) u_pfr_top (.i_clk(i_clk), .i_rst(i_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_pulse(i_pulse), .i_start(i_start), .i_saved_count(saved[9:0]),
		.i_saved_valid(saved[10]),
		.o_count(o_count), .o_relay_one(o_relay_one), .o_relay_two(o_relay_two),
		.o_cycle_active(o_cycle_active));
	pfr_pulse_src u_pfr_pulse_src (.i_clk(i_clk), .o_pulse(i_pulse));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (watch && {o_relay_two, o_relay_one} !== 2'b11) begin
			drops++;
		end
	end
	// ----------------------------------------------------------------
	// Bus, wait and compare helpers
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 100);
		chk(o_pready, 1'b1, "bus answer");
		if (o_pready !== 1'b1) finish_test();
		rdata = o_prdata;
		rerr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask : apb
	function automatic logic [31:0] ctl(input logic b, input logic d, input logic a,
			input logic [3:0] f, input pfr_relay_mode_t m1, input pfr_relay_mode_t m2);
		return {20'h00000, m2, m1, f, 1'b0, a, d, b};
	endfunction : ctl
	task automatic cfg(input logic [31:0] c, input logic [9:0] thr, input logic [9:0] adv,
			input logic [9:0] h1, input logic [9:0] h2, input logic [9:0] dly);
		apb(1'b1, REG_CTRL, c);
		apb(1'b1, REG_THRESH, {6'h00, adv, 6'h00, thr});
		apb(1'b1, REG_HOLD, {6'h00, h2, 6'h00, h1});
		apb(1'b1, REG_DELAY, {22'h000000, dly});
		apb(1'b1, REG_CMD, 32'h00000001);
	endtask : cfg
	task automatic wait_r1(input logic v, input int lim);
		int n;
		n = 0;
		while (o_relay_one !== v && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		chk(o_relay_one, v, "relay one wait");
		if (o_relay_one !== v) finish_test();
	endtask : wait_r1
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset(input logic [10:0] s);
		saved <= s;
		i_rst <= 1'b1;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk(o_count, s[10] ? s[9:0] : 10'h000, "restored count");
		chk({o_relay_two, o_relay_one, o_cycle_active}, 3'h0, "power-up state");
		apb(1'b0, 12'h020, 32'h00000000);
		chk({rerr, rdata[30:0]}, 32'h80000000, "unmapped read");
		$display("test reset done");
	endtask : t_reset
	task automatic t_filter;
		int lim;
		logic [9:0] c;
		for (int f = 0; f <= 9; f++) begin
			lim = (f == 0) ? FILT_OFF_CYC : (FB + f - 1) / f;
			apb(1'b1, REG_CTRL, ctl(0, 0, 0, 4'(f), RELAY_DISABLED, RELAY_DISABLED));
			c = o_count;
			u_pfr_pulse_src.send(1, lim - 30, lim + 30, 0);
			chk(o_count, c, "short pulse counted");
			u_pfr_pulse_src.send(1, lim + 30, lim + 30, 3);
			chk(o_count, (c == COUNT_MAX) ? COUNT_ZERO : c + 10'h001, "pulse count");
		end
		$display("test filter done");
	endtask : t_filter
	task automatic t_batch_up;
		cfg(ctl(1, 0, 0, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_OPEN_ACTIVE), 10'h004, 10'h002,
			10'h000, 10'h000, 10'h000);
		chk({o_relay_two, o_relay_one, o_cycle_active}, 3'h3, "batch start");
		u_pfr_pulse_src.send(2, 240, 240, 0);
		chk({o_relay_two, o_relay_one}, 2'h3, "advance release");
		u_pfr_pulse_src.send(2, 240, 240, 0);
		chk({o_relay_two, o_relay_one, o_cycle_active}, 3'h4, "main release");
		repeat (200) @(posedge i_clk);
		chk({o_relay_two, o_relay_one}, 2'h2, "zero hold kept");
		i_start <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_start <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk({o_relay_two, o_relay_one, o_cycle_active}, 3'h3, "pin start");
		$display("test batch up done");
	endtask : t_batch_up
	task automatic t_hold;
		cfg(ctl(1, 0, 0, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_CLOSED_ACTIVE), 10'h001, 10'h000,
			10'h014, 10'h000, 10'h000);
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk({o_relay_two, o_relay_one}, 2'h0, "held inactive");
		wait_r1(1'b1, 200);
		chk(o_relay_two, 1'b0, "zero hold relay");
		apb(1'b1, REG_HOLD, 32'h00000032);
		apb(1'b1, REG_CMD, 32'h00000001);
		u_pfr_pulse_src.send(1, 240, 240, 0);
		apb(1'b1, REG_CMD, 32'h00000001);
		chk({o_relay_two, o_relay_one}, 2'h3, "manual start ends hold");
		$display("test hold done");
	endtask : t_hold
	task automatic t_auto;
		cfg(ctl(1, 0, 1, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_CLOSED_ACTIVE), 10'h001, 10'h000,
			10'h032, 10'h000, 10'h005);
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk({o_relay_two, o_relay_one, o_cycle_active}, 3'h5, "auto start");
		chk(o_count, 10'h000, "auto start count");
		wait_r1(1'b1, 900);
		apb(1'b1, REG_HOLD, 32'h00000000);
		apb(1'b1, REG_DELAY, 32'h00000000);
		apb(1'b1, REG_CMD, 32'h00000001);
		watch = 1'b1;
		u_pfr_pulse_src.send(3, 240, 240, 0);
		watch = 1'b0;
		chk(drops, 0, "relay dropped under zero delay");
		$display("test autoreset done");
	endtask : t_auto
	task automatic t_down;
		cfg(ctl(1, 1, 0, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_CLOSED_ACTIVE), 10'h003, 10'h001,
			10'h000, 10'h000, 10'h000);
		chk({o_relay_two, o_relay_one, o_count}, 12'hC03, "down start");
		u_pfr_pulse_src.send(2, 240, 240, 0);
		chk({o_relay_two, o_relay_one, o_count}, 12'h401, "advance at threshold");
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk({o_relay_two, o_relay_one, o_count}, 12'h000, "release at zero");
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk(o_count, COUNT_MAX, "down wrap");
		$display("test down done");
	endtask : t_down
	task automatic t_std;
		cfg(ctl(0, 0, 0, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_CLOSED_ACTIVE), 10'h002, 10'h000,
			10'h014, 10'h000, 10'h000);
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk({o_relay_two, o_relay_one}, 2'h0, "before threshold");
		u_pfr_pulse_src.send(1, 240, 240, 0);
		chk({o_relay_two, o_relay_one}, 2'h1, "active at threshold");
		wait_r1(1'b0, 200);
		apb(1'b1, REG_CTRL, ctl(0, 0, 1, 4'h9, RELAY_CLOSED_ACTIVE, RELAY_CLOSED_ACTIVE));
		apb(1'b1, REG_DELAY, 32'h00000002);
		apb(1'b1, REG_CMD, 32'h00000001);
		u_pfr_pulse_src.send(2, 240, 240, 0);
		chk({o_cycle_active, o_count}, 11'h400, "standard auto start");
		$display("test standard done");
	endtask : t_std
	task automatic t_bus;
		apb(1'b1, REG_CTRL, ctl(0, 0, 0, 4'h9, RELAY_BUS_DRIVEN, RELAY_CLOSED_ACTIVE));
		apb(1'b1, REG_CMD, 32'h00000001);
		apb(1'b1, REG_RELAY, 32'h00000003);
		chk({o_relay_two, o_relay_one}, 2'h1, "relay write");
		apb(1'b0, REG_RELAY, 32'h00000000);
		chk(rdata, 32'h00000001, "relay read");
		apb(1'b1, REG_DELAY, 32'h000003FF);
		apb(1'b0, REG_DELAY, 32'h00000000);
		chk(rdata, 32'h000003E7, "delay clamp");
		apb(1'b1, REG_RELAY, 32'h00000000);
		chk(o_relay_one, 1'b0, "relay clear");
		u_pfr_pulse_src.send(2, 240, 240, 0);
		chk(o_relay_one, 1'b0, "bus relay ignores counter");
		$display("test bus relay done");
	endtask : t_bus
	initial begin
		fails = 0;
		checks_done = 0;
		drops = 0;
		watch = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h00000000;
		i_start = 1'b0;
		t_reset(11'h7E6);
		t_filter();
		t_batch_up();
		t_hold();
		t_auto();
		t_down();
		t_std();
		t_bus();
		apb(1'b1, REG_CMD, 32'h00000001);
		t_reset(11'h005);
		finish_test();
	end
endmodule : pfr_top_tb_top
`default_nettype wire
